// ==== design/pbpc_pkg.sv ====
// constants for the port, blink-phase and pwm control core
// assumes a single 125 MHz clock and a synchronous, active-low reset
package pbpc_pkg;
    // ========================================
    // register offsets
    localparam logic [7:0] ADDR_IN_LO = 8'h00;
    localparam logic [7:0] ADDR_IN_HI = 8'h01;
    localparam logic [7:0] ADDR_PH0_LO = 8'h02;
    localparam logic [7:0] ADDR_PH0_HI = 8'h03;
    localparam logic [7:0] ADDR_DIR_LO = 8'h06;
    localparam logic [7:0] ADDR_DIR_HI = 8'h07;
    localparam logic [7:0] ADDR_PH1_LO = 8'h0a;
    localparam logic [7:0] ADDR_PH1_HI = 8'h0b;
    localparam logic [7:0] ADDR_MASTER = 8'h0e;
    localparam logic [7:0] ADDR_SETUP = 8'h0f;
    localparam logic [7:0] ADDR_INTENS_BASE = 8'h10;
    localparam logic [7:0] ADDR_INTENS_LAST = 8'h17;
    // ========================================
    // device_setup field positions
    localparam int SETUP_ALT_EN = 0;
    localparam int SETUP_FLIP = 1;
    localparam int SETUP_GLOBAL = 2;
    localparam int SETUP_IRQ_EN = 3;
    localparam int SETUP_EXTRA_PH0 = 4;
    localparam int SETUP_EXTRA_PH1 = 5;
    localparam int SETUP_PIN_STAT = 6;
    localparam int SETUP_CHG_STAT = 7;
    // ========================================
    // reset values
    localparam logic [7:0] RST_DIR = 8'hff;
    localparam logic [7:0] RST_PHASE = 8'hff;
    localparam logic [7:0] RST_SETUP = 8'h3c;
    localparam logic [7:0] RST_MASTER = 8'h00;
    localparam logic [7:0] RST_INTENS = 8'hff;
    localparam logic [7:0] RDATA_NONE = 8'h00;
    // ========================================
    // timing
    localparam int unsigned CLK_HZ = 125000000;
    localparam int unsigned OSC_HZ = 32000;
    localparam int unsigned OSC_DIV = CLK_HZ / OSC_HZ;
    localparam int unsigned PWM_SLOTS = 15;
    localparam int unsigned PWM_CYCLES = 16;
    localparam int unsigned PWM_STEPS = PWM_SLOTS * PWM_CYCLES;
    localparam logic [3:0] INTENS_FULL = 4'hf;
    localparam logic [3:0] MASTER_OFF = 4'h0;
endpackage

// ==== design/pbpc_pwm_timer.sv ====
// pwm frame timer: divider to the slow step rate, cycle and slot counters
// assumes i_run low holds everything at zero so the slow rate is stopped
`timescale 1ns/10ps
module pbpc_pwm_timer #(
    parameter int unsigned DIV = pbpc_pkg::OSC_DIV,
    parameter int unsigned CYCLES = pbpc_pkg::PWM_CYCLES,
    parameter int unsigned SLOTS = pbpc_pkg::PWM_SLOTS
) (
    input wire logic i_sys_clk,
    input wire logic i_rstn,
    input wire logic i_run,
    output logic o_step,
    output logic [3:0] o_cycle,
    output logic [3:0] o_slot
);
    // the counters are four bits and the divider sixteen bits wide
    if (DIV < 1 || DIV > 65535 || CYCLES != 16 ||
        SLOTS > 15 || SLOTS < 1) begin : g_bad_params
        $error("pbpc_pwm_timer: unsupported parameters");
    end

    logic [15:0] div_r;

    // ========================================
    // divider: the slow rate exists only while pwm is in use
    always_ff @(posedge i_sys_clk) begin
        if (!i_rstn || !i_run) begin
            div_r <= 16'h0000;
        end else if (div_r == 16'(DIV - 1)) begin
            div_r <= 16'h0000;
        end else begin
            div_r <= div_r + 16'h0001;
        end
    end

    assign o_step = i_run && (div_r == 16'(DIV - 1));

    // ========================================
    // 16 cycles per slot, 15 slots per period
    always_ff @(posedge i_sys_clk) begin
        if (!i_rstn || !i_run) begin
            o_cycle <= 4'h0;
            o_slot <= 4'h0;
        end else if (o_step) begin
            o_cycle <= o_cycle + 4'h1;
            if (o_cycle == 4'(CYCLES - 1)) begin
                o_slot <= (o_slot == 4'(SLOTS - 1)) ? 4'h0 : o_slot + 4'h1;
            end
        end
    end
endmodule

// ==== design/pbpc_core.sv ====
// port direction, blink-phase selection, pwm shaping and register file
// assumes a register port decoded from the serial bus, synchronous pins
`timescale 1ns/10ps
module pbpc_core #(
    parameter int unsigned PORTS = 16,
    parameter int unsigned OSC_DIV = pbpc_pkg::OSC_DIV
) (
    input wire logic i_sys_clk,
    input wire logic i_rstn,
    input wire logic i_wr_en,
    input wire logic i_rd_en,
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wdata,
    output logic [7:0] o_rdata,
    output logic o_rvalid,
    input wire logic [15:0] i_port_level,
    output logic [15:0] o_port_out,
    output logic [15:0] o_port_oe_n,
    input wire logic i_phase_pin,
    output logic o_extra_out,
    output logic o_extra_oe_n
);
    // the port maps and register pairs are laid out for sixteen ports
    if (PORTS != 16) begin : g_bad_ports
        $error("pbpc_core: only sixteen ports are supported");
    end
    // the step divider inside the timer is sixteen bits wide
    if (OSC_DIV < 1 || OSC_DIV > 65535) begin : g_bad_div
        $error("pbpc_core: step divider out of range");
    end

    logic [15:0] in_r;
    logic [15:0] in_prev_r;
    logic [15:0] dir_r;
    logic [15:0] ph0_r;
    logic [15:0] ph1_r;
    logic [7:0] setup_r;
    logic [7:0] master_r;
    logic [63:0] intens_r;
    logic chg_r;
    logic [7:0] rdata_nxt;
    logic phase;
    logic pwm_on;
    logic step;
    logic [3:0] cycle;
    logic [3:0] slot;
    logic [15:0] sel_bits;
    logic [15:0] lvl;
    logic chg_det;
    logic chg_clr;
    logic extra_lvl;
    logic wr_intens;
    logic [2:0] intens_idx;

    // ========================================
    // input sampling and change detect
    always_ff @(posedge i_sys_clk) begin
        // pins are sampled in reset too, so release is not seen as a change
        if (!i_rstn) begin
            in_r <= i_port_level;
            in_prev_r <= i_port_level;
        end else begin
            in_r <= i_port_level;
            in_prev_r <= in_r;
        end
    end

    assign chg_det = |((in_r ^ in_prev_r) & dir_r);
    assign chg_clr = i_rd_en && (i_addr == pbpc_pkg::ADDR_IN_LO ||
                                 i_addr == pbpc_pkg::ADDR_IN_HI);

    // a change in the same cycle as the clearing read stays flagged
    always_ff @(posedge i_sys_clk) begin
        if (!i_rstn) begin
            chg_r <= 1'b0;
        end else if (chg_det) begin
            chg_r <= 1'b1;
        end else if (chg_clr) begin
            chg_r <= 1'b0;
        end
    end

    // ========================================
    // register writes
    assign wr_intens = i_wr_en && i_addr >= pbpc_pkg::ADDR_INTENS_BASE &&
                       i_addr <= pbpc_pkg::ADDR_INTENS_LAST;
    assign intens_idx = i_addr[2:0];

    always_ff @(posedge i_sys_clk) begin
        if (!i_rstn) begin
            dir_r <= {2{pbpc_pkg::RST_DIR}};
        end else if (i_wr_en && i_addr == pbpc_pkg::ADDR_DIR_LO) begin
            dir_r[7:0] <= i_wdata;
        end else if (i_wr_en && i_addr == pbpc_pkg::ADDR_DIR_HI) begin
            dir_r[15:8] <= i_wdata;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_rstn) begin
            ph0_r <= {2{pbpc_pkg::RST_PHASE}};
            ph1_r <= {2{pbpc_pkg::RST_PHASE}};
        end else if (i_wr_en) begin
            case (i_addr)
                pbpc_pkg::ADDR_PH0_LO: ph0_r[7:0] <= i_wdata;
                pbpc_pkg::ADDR_PH0_HI: ph0_r[15:8] <= i_wdata;
                pbpc_pkg::ADDR_PH1_LO: ph1_r[7:0] <= i_wdata;
                pbpc_pkg::ADDR_PH1_HI: ph1_r[15:8] <= i_wdata;
                default: ;
            endcase
        end
    end

    // status bits 6 and 7 are not stored, they are read live
    always_ff @(posedge i_sys_clk) begin
        if (!i_rstn) begin
            setup_r <= pbpc_pkg::RST_SETUP;
        end else if (i_wr_en && i_addr == pbpc_pkg::ADDR_SETUP) begin
            setup_r <= {2'b00, i_wdata[5:0]};
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_rstn) begin
            master_r <= pbpc_pkg::RST_MASTER;
        end else if (i_wr_en && i_addr == pbpc_pkg::ADDR_MASTER) begin
            master_r <= i_wdata;
        end
    end

    // two ports per byte, lower port in the low nibble
    always_ff @(posedge i_sys_clk) begin
        if (!i_rstn) begin
            intens_r <= {8{pbpc_pkg::RST_INTENS}};
        end else if (wr_intens) begin
            intens_r[intens_idx*8 +: 8] <= i_wdata;
        end
    end

    // ========================================
    // register reads, answered one cycle after the strobe
    always_comb begin
        rdata_nxt = pbpc_pkg::RDATA_NONE;
        case (i_addr)
            pbpc_pkg::ADDR_IN_LO: rdata_nxt = in_r[7:0];
            pbpc_pkg::ADDR_IN_HI: rdata_nxt = in_r[15:8];
            pbpc_pkg::ADDR_PH0_LO: rdata_nxt = ph0_r[7:0];
            pbpc_pkg::ADDR_PH0_HI: rdata_nxt = ph0_r[15:8];
            pbpc_pkg::ADDR_PH1_LO: rdata_nxt = ph1_r[7:0];
            pbpc_pkg::ADDR_PH1_HI: rdata_nxt = ph1_r[15:8];
            pbpc_pkg::ADDR_DIR_LO: rdata_nxt = dir_r[7:0];
            pbpc_pkg::ADDR_DIR_HI: rdata_nxt = dir_r[15:8];
            pbpc_pkg::ADDR_MASTER: rdata_nxt = master_r;
            pbpc_pkg::ADDR_SETUP: begin
                rdata_nxt = setup_r;
                rdata_nxt[pbpc_pkg::SETUP_PIN_STAT] = i_phase_pin;
                rdata_nxt[pbpc_pkg::SETUP_CHG_STAT] = chg_r;
            end
            default: begin
                if (i_addr >= pbpc_pkg::ADDR_INTENS_BASE &&
                    i_addr <= pbpc_pkg::ADDR_INTENS_LAST) begin
                    rdata_nxt = intens_r[intens_idx*8 +: 8];
                end
            end
        endcase
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_rstn) begin
            o_rdata <= 8'h00;
            o_rvalid <= 1'b0;
        end else begin
            o_rvalid <= i_rd_en;
            if (i_rd_en) begin
                o_rdata <= rdata_nxt;
            end
        end
    end

    // ========================================
    // phase selection and pwm frame
    assign phase = setup_r[pbpc_pkg::SETUP_ALT_EN] &&
        (setup_r[pbpc_pkg::SETUP_FLIP] ^ i_phase_pin);
    assign sel_bits = phase ? ph1_r : ph0_r;
    assign pwm_on = master_r[7:4] != pbpc_pkg::MASTER_OFF;

    pbpc_pwm_timer #(
        .DIV(OSC_DIV),
        .CYCLES(pbpc_pkg::PWM_CYCLES),
        .SLOTS(pbpc_pkg::PWM_SLOTS)
    ) u_timer (
        .i_sys_clk(i_sys_clk),
        .i_rstn(i_rstn),
        .i_run(pwm_on),
        .o_step(step),
        .o_cycle(cycle),
        .o_slot(slot)
    );

    // with pwm running below full intensity: on-level for the first n+1 cycles of each gated slot, else inverted
    function automatic logic shape(input logic bit_lvl,
                                   input logic [3:0] inten,
                                   input logic run,
                                   input logic [3:0] mst,
                                   input logic [3:0] sl,
                                   input logic [3:0] cy);
        logic on;
        on = (sl < mst) && (cy <= inten);
        if (!run || inten == pbpc_pkg::INTENS_FULL) begin
            shape = bit_lvl;
        end else begin
            shape = on ? bit_lvl : ~bit_lvl;
        end
    endfunction

    always_comb begin
        for (int i = 0; i < 16; i++) begin
            lvl[i] = shape(sel_bits[i],
                setup_r[pbpc_pkg::SETUP_GLOBAL] ? master_r[3:0] :
                    intens_r[i*4 +: 4],
                pwm_on, master_r[7:4], slot, cycle);
        end
    end

    // open drain: the pin is only ever pulled low or released
    assign o_port_out = 16'h0000;
    assign o_port_oe_n = dir_r | lvl;

    // ========================================
    // extra output: change flag or phase bits
    assign extra_lvl = shape(phase ? setup_r[pbpc_pkg::SETUP_EXTRA_PH1] :
                                     setup_r[pbpc_pkg::SETUP_EXTRA_PH0],
                             master_r[3:0], pwm_on, master_r[7:4],
                             slot, cycle);
    assign o_extra_out = 1'b0;
    assign o_extra_oe_n = setup_r[pbpc_pkg::SETUP_IRQ_EN] ? !chg_r :
                          extra_lvl;

    // ========================================
    // checks
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_rstn);

    sequence s_dir_write;
        i_wr_en && i_addr == pbpc_pkg::ADDR_DIR_LO;
    endsequence

    sequence s_dir_read;
        i_rd_en && !i_wr_en && i_addr == pbpc_pkg::ADDR_DIR_LO;
    endsequence

    // a change seen with the interrupt on and no setup write in flight
    sequence s_change_irq;
        chg_det && setup_r[pbpc_pkg::SETUP_IRQ_EN] &&
            !(i_wr_en && i_addr == pbpc_pkg::ADDR_SETUP);
    endsequence

    chk_setup_pin: assert property (
        i_rd_en && i_addr == pbpc_pkg::ADDR_SETUP |=>
            o_rvalid &&
            o_rdata[pbpc_pkg::SETUP_PIN_STAT] == $past(i_phase_pin))
        else $error("setup bit 6 does not show the phase pin");

    chk_change_flag: assert property (
        s_change_irq |=> chg_r && !o_extra_oe_n)
        else $error("change not flagged on the shared pin");

    chk_flag_clear: assert property (
        chg_clr && !chg_det |=> !chg_r)
        else $error("change flag survives the input read");

    chk_static_phase: assert property (
        !setup_r[pbpc_pkg::SETUP_ALT_EN] && !pwm_on |->
            o_port_oe_n == (dir_r | ph0_r))
        else $error("static phase 0 not driven");

    chk_alt_phase: assert property (
        setup_r[pbpc_pkg::SETUP_ALT_EN] && !pwm_on &&
            (setup_r[pbpc_pkg::SETUP_FLIP] ^ i_phase_pin) |->
            o_port_oe_n == (dir_r | ph1_r))
        else $error("phase 1 not selected");

    chk_input_released: assert property (
        (~o_port_oe_n & dir_r) == 16'h0000)
        else $error("input port pulled low");

    chk_dir_rw: assert property (
        s_dir_write ##1 !i_wr_en ##1 s_dir_read |=>
            o_rdata == $past(i_wdata, 3))
        else $error("direction readback mismatch");

    chk_ph0_write: assert property (
        i_wr_en && i_addr == pbpc_pkg::ADDR_PH0_LO |=>
            ph0_r[7:0] == $past(i_wdata))
        else $error("phase 0 low byte not stored");

    chk_phase_read: assert property (
        i_rd_en && i_addr == pbpc_pkg::ADDR_PH0_LO |=>
            o_rdata == $past(ph0_r[7:0]))
        else $error("phase 0 readback is not the stored value");

    chk_input_read: assert property (
        i_rd_en && i_addr == pbpc_pkg::ADDR_IN_HI |=>
            o_rdata == $past(in_r[15:8]))
        else $error("input level readback mismatch");

    chk_read_answer: assert property (
        i_rd_en |=> o_rvalid)
        else $error("read strobe not answered");

    chk_read_quiet: assert property (
        !i_rd_en |=> !o_rvalid)
        else $error("read answer without a strobe");

    chk_osc_stop: assert property (
        !pwm_on |=> cycle == 4'h0 && slot == 4'h0 && !step)
        else $error("pwm timer runs while pwm is off");

    chk_slot_wrap: assert property (
        step && cycle == 4'hf && slot == 4'he |=> slot == 4'h0)
        else $error("slot count does not wrap after fifteen");

    chk_full_static: assert property (
        setup_r[pbpc_pkg::SETUP_GLOBAL] &&
            master_r[3:0] == pbpc_pkg::INTENS_FULL &&
            !setup_r[pbpc_pkg::SETUP_ALT_EN] |->
            o_port_oe_n == (dir_r | ph0_r))
        else $error("full intensity is not static");

    chk_gate_on: assert property (
        pwm_on && slot < master_r[7:4] && cycle <= master_r[3:0] &&
            setup_r[pbpc_pkg::SETUP_GLOBAL] &&
            master_r[3:0] != pbpc_pkg::INTENS_FULL &&
            !setup_r[pbpc_pkg::SETUP_ALT_EN] |->
            o_port_oe_n == (dir_r | ph0_r))
        else $error("gated slot not at the on-level");

    chk_gate_off: assert property (
        pwm_on && slot >= master_r[7:4] &&
            setup_r[pbpc_pkg::SETUP_GLOBAL] &&
            master_r[3:0] != pbpc_pkg::INTENS_FULL &&
            !setup_r[pbpc_pkg::SETUP_ALT_EN] |->
            o_port_oe_n == (dir_r | ~ph0_r))
        else $error("ungated slot not at opposite level");

    chk_extra_static: assert property (
        !setup_r[pbpc_pkg::SETUP_IRQ_EN] &&
            !setup_r[pbpc_pkg::SETUP_ALT_EN] && !pwm_on |->
            o_extra_oe_n == setup_r[pbpc_pkg::SETUP_EXTRA_PH0])
        else $error("extra output ignores its phase 0 bit");

    chk_extra_alt: assert property (
        !setup_r[pbpc_pkg::SETUP_IRQ_EN] &&
            setup_r[pbpc_pkg::SETUP_ALT_EN] && !pwm_on &&
            (setup_r[pbpc_pkg::SETUP_FLIP] ^ i_phase_pin) |->
            o_extra_oe_n == setup_r[pbpc_pkg::SETUP_EXTRA_PH1])
        else $error("extra output ignores its phase 1 bit");
endmodule

// ==== bench/pbpc_host_model.sv ====
// host side of the register port: issues single write and read strobes
// assumes the core answers a read with o_rvalid one cycle after the strobe
`timescale 1ns/10ps
module pbpc_host_model (
    input wire logic i_sys_clk,
    input wire logic [7:0] i_rdata,
    input wire logic i_rvalid,
    output logic o_wr_en,
    output logic o_rd_en,
    output logic [7:0] o_addr,
    output logic [7:0] o_wdata
);
    // ========================================
    // idle state
    initial begin
        o_wr_en = 1'b0;
        o_rd_en = 1'b0;
        o_addr = 8'h55;
        o_wdata = 8'haa;
    end

    // ========================================
    // bus cycles, driven on the falling edge
    // released address and data show the inverse, never a stale value
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge i_sys_clk);
        o_wr_en = 1'b1;
        o_addr = a;
        o_wdata = d;
        @(negedge i_sys_clk);
        o_wr_en = 1'b0;
        o_addr = ~a;
        o_wdata = ~d;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        int n;
        @(negedge i_sys_clk);
        o_rd_en = 1'b1;
        o_addr = a;
        @(negedge i_sys_clk);
        o_rd_en = 1'b0;
        o_addr = ~a;
        n = 0;
        while (i_rvalid !== 1'b1 && n < 4) begin
            @(negedge i_sys_clk);
            n++;
        end
        d = (i_rvalid === 1'b1) ? i_rdata : 8'hxx;
    endtask
endmodule

// ==== bench/port_blink_pwm_control_test.sv ====
// self-checking bench for the port, blink-phase and pwm control core
// assumes open-drain port pins with pull-ups and a small pwm divider
`timescale 1ns/10ps
module port_blink_pwm_control_test;
    localparam int unsigned DIV = 4;
    logic i_sys_clk, i_rstn, i_phase_pin;
    logic [15:0] ext_level;
    logic wr_en, rd_en, rvalid, extra_out, extra_oe_n;
    logic [7:0] addr, wdata, rdata;
    logic [15:0] port_lvl, port_out, port_oe_n;
    int errors, checks, cycles;

    // pull-up on every port pin; a low oe_n wins over the outside level
    assign port_lvl = ext_level & port_oe_n;

    pbpc_host_model host (.i_sys_clk(i_sys_clk), .i_rdata(rdata),
        .i_rvalid(rvalid), .o_wr_en(wr_en), .o_rd_en(rd_en),
        .o_addr(addr), .o_wdata(wdata));

    pbpc_core #(.PORTS(16), .OSC_DIV(DIV)) i_dut (.i_sys_clk(i_sys_clk),
        .i_rstn(i_rstn), .i_wr_en(wr_en), .i_rd_en(rd_en), .i_addr(addr),
        .i_wdata(wdata), .o_rdata(rdata), .o_rvalid(rvalid),
        .i_port_level(port_lvl), .o_port_out(port_out),
        .o_port_oe_n(port_oe_n), .i_phase_pin(i_phase_pin),
        .o_extra_out(extra_out), .o_extra_oe_n(extra_oe_n));

    // ========================================
    // clock and hang guard
    initial begin
        i_sys_clk = 1'b0;
        forever #4 i_sys_clk = ~i_sys_clk;
    end

    always @(posedge i_sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            give_verdict();
        end
    end

    // ========================================
    // comparisons and verdict
    task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic cmp1(input logic got, input logic exp);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic cmp_n(input int got, input int exp);
        checks++;
        if (got != exp) begin
            errors++;
            $display("unexpected at %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        host.rd(a, d);
        cmp8(d, exp);
    endtask

    task automatic give_verdict();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // ========================================
    // scenarios
    task automatic test_reset_regs();
        rd_chk(pbpc_pkg::ADDR_DIR_LO, 8'hff);
        rd_chk(pbpc_pkg::ADDR_DIR_HI, 8'hff);
        rd_chk(pbpc_pkg::ADDR_PH0_LO, 8'hff);
        rd_chk(pbpc_pkg::ADDR_PH1_HI, 8'hff);
        host.wr(pbpc_pkg::ADDR_IN_LO, 8'h00);
        rd_chk(8'h20, 8'h00);
        cmp8(port_oe_n[7:0], 8'hff);
        rd_chk(pbpc_pkg::ADDR_SETUP, 8'h3c);
        cmp1(extra_oe_n, 1'b1);
        cmp8(port_out[7:0], 8'h00);
        cmp8(port_out[15:8], 8'h00);
        cmp1(extra_out, 1'b0);
        $display("test reset_regs done");
    endtask

    task automatic test_phase_select();
        logic e, b, pin, d4, d5, ph;
        host.wr(pbpc_pkg::ADDR_DIR_LO, 8'h00);
        rd_chk(pbpc_pkg::ADDR_DIR_LO, 8'h00);
        host.wr(pbpc_pkg::ADDR_PH0_LO, 8'h5a);
        host.wr(pbpc_pkg::ADDR_PH1_LO, 8'ha5);
        // pins held low outside, so a readback equal to the pin is no proof
        ext_level[7:0] = 8'h00;
        rd_chk(pbpc_pkg::ADDR_PH0_LO, 8'h5a);
        rd_chk(pbpc_pkg::ADDR_PH1_LO, 8'ha5);
        ext_level[7:0] = 8'hff;
        for (int k = 0; k < 32; k++) begin
            e = k[0];
            b = k[1];
            pin = k[2];
            d4 = k[3];
            d5 = k[4];
            i_phase_pin = pin;
            host.wr(pbpc_pkg::ADDR_SETUP, {2'b00, d5, d4, 2'b01, b, e});
            ph = e & (b ^ pin);
            cmp8(port_oe_n[7:0], ph ? 8'ha5 : 8'h5a);
            cmp8(port_oe_n[15:8], 8'hff);
            cmp1(extra_oe_n, ph ? d5 : d4);
        end
        $display("test phase_select done");
    endtask

    task automatic test_inputs();
        logic [7:0] d;
        i_phase_pin = 1'b1;
        host.wr(pbpc_pkg::ADDR_SETUP, 8'h0c);
        @(negedge i_sys_clk);
        ext_level[15:8] = 8'h96;
        repeat (3) @(negedge i_sys_clk);
        rd_chk(pbpc_pkg::ADDR_IN_HI, 8'h96);
        rd_chk(pbpc_pkg::ADDR_IN_LO, 8'h5a);
        rd_chk(pbpc_pkg::ADDR_SETUP, 8'h4c);
        cmp1(extra_oe_n, 1'b1);
        ext_level[8] = 1'b1;
        repeat (3) @(negedge i_sys_clk);
        cmp1(extra_oe_n, 1'b0);
        rd_chk(pbpc_pkg::ADDR_SETUP, 8'hcc);
        host.rd(pbpc_pkg::ADDR_IN_HI, d);
        cmp8(d, 8'h97);
        i_phase_pin = 1'b0;
        rd_chk(pbpc_pkg::ADDR_SETUP, 8'h0c);
        cmp1(extra_oe_n, 1'b1);
        $display("test inputs done");
    endtask

    task automatic test_pwm();
        logic [7:0] mst [5];
        logic [3:0] h, l;
        int cnt, exp, period;
        mst = '{8'h13, 8'hf0, 8'h5e, 8'h1f, 8'h03};
        // whole period is a window of DIV * 240 clocks whatever the phase
        period = DIV * pbpc_pkg::PWM_STEPS;
        for (int k = 0; k < 5; k++) begin
            host.wr(pbpc_pkg::ADDR_MASTER, mst[k]);
            h = mst[k][7:4];
            l = mst[k][3:0];
            exp = (h == 0 || l == 4'hf) ? period : h * (l + 1) * DIV;
            cnt = 0;
            repeat (period) begin
                @(negedge i_sys_clk);
                if (port_oe_n[0] === 1'b0) begin
                    cnt++;
                end
            end
            cmp_n(cnt, exp);
        end
        $display("test pwm done");
    endtask

    // ========================================
    // main sequence
    initial begin
        errors = 0;
        checks = 0;
        cycles = 0;
        i_rstn = 1'b0;
        i_phase_pin = 1'b0;
        ext_level = 16'hffff;
        repeat (16) @(posedge i_sys_clk);
        @(negedge i_sys_clk);
        i_rstn = 1'b1;
        test_reset_regs();
        test_phase_select();
        test_inputs();
        test_pwm();
        give_verdict();
    end
endmodule
